// *** bench/pll_detect_net.sv ***
// pll_detect_net: behavioural model of the divider, zener and ntc network
// assumes the comparator output only tracks the pin during the off-time
`timescale 1ns/1ps
module pll_detect_net
(
	// clock
	input wire logic clock,
	// gate state and fault shape
	input wire logic gate_request,
	input wire logic [7:0] spike_at,
	input wire logic [7:0] spike_len,
	// comparator output
	output logic trip_compare
);
	logic [7:0] off_time = 8'h00;
	// ==========================================
	// off-time timer and pin level
	// the pull-down holds the pin low while no fault is injected
	always @(posedge clock)
	begin
		if (gate_request)
			off_time <= 8'h00;
		else if (off_time != 8'hff)
			off_time <= off_time + 8'h01;
		trip_compare <= !gate_request && off_time >= spike_at
			&& off_time < spike_at + spike_len;
	end
endmodule

// *** bench/testbench.sv ***
// testbench: scenario tasks for the latch-off protection logic
// assumes shortened blanking and qualify counts of 2 and 3 cycles
`timescale 1ns/1ps
module testbench;
	import pll_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic gate_request = 1'b0;
	logic switch_clock = 1'b0;
	logic trip_compare;
	logic gate_drive;
	logic latched;
	logic event_pulse;
	logic [EVENT_W-1:0] event_count;
	logic [7:0] spike_at = 8'h00;
	logic [7:0] spike_len = 8'h00;
	int n_pulse = 0;
	int n_gate = 0;
	int n_mismatch = 0;
	int n_compared = 0;
	// ==========================================
	// clock, design and network
	initial forever #2.5 clock = ~clock;
	pll_latch_off #(.BLANK(2), .QUALIFY(3), .EVENTS(4)) uut
	(
		.clock(clock),
		.arst_n(arst_n),
		.trip_compare(trip_compare),
		.gate_request(gate_request),
		.switch_clock(switch_clock),
		.gate_drive(gate_drive),
		.latched(latched),
		.event_count(event_count),
		.event_pulse(event_pulse)
	);
	pll_detect_net net
	(
		.clock(clock),
		.gate_request(gate_request),
		.spike_at(spike_at),
		.spike_len(spike_len),
		.trip_compare(trip_compare)
	);
	always @(posedge clock)
	begin
		if (event_pulse === 1'b1)
			n_pulse <= n_pulse + 1;
		if (gate_drive === 1'b1)
			n_gate <= n_gate + 1;
	end
	// ==========================================
	// checking and closing
	task chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// one switching cycle: on-time, then an off-time with a pin fault
	task cyc(input int at, input int len, input int ev, input int cnt,
		input logic lat, input logic drv);
		int p0;
		int g0;
		p0 = n_pulse;
		g0 = n_gate;
		@(posedge clock);
		spike_at <= 8'(at);
		spike_len <= 8'(len);
		switch_clock <= 1'b1;
		gate_request <= 1'b1;
		repeat (4) @(posedge clock);
		switch_clock <= 1'b0;
		repeat (6) @(posedge clock);
		gate_request <= 1'b0;
		repeat (30) @(posedge clock);
		#1;
		chk("event_pulse", 8'(n_pulse - p0), 8'(ev));
		chk("event_count", {5'h00, event_count}, 8'(cnt));
		chk("latched", {7'h00, latched}, {7'h00, lat});
		chk("gate_drive", {7'h00, n_gate > g0}, {7'h00, drv});
	endtask
	// ==========================================
	// scenarios
	initial
	begin
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		cyc(0, 3, 0, 0, 1'b0, 1'b1);
		cyc(10, 2, 0, 0, 1'b0, 1'b1);
		cyc(10, 8, 1, 1, 1'b0, 1'b1);
		cyc(10, 8, 1, 2, 1'b0, 1'b1);
		cyc(10, 8, 1, 3, 1'b0, 1'b1);
		cyc(10, 0, 0, 3, 1'b0, 1'b1);
		cyc(10, 8, 1, 1, 1'b0, 1'b1);
		cyc(10, 8, 1, 2, 1'b0, 1'b1);
		cyc(10, 8, 1, 3, 1'b0, 1'b1);
		cyc(10, 8, 1, 4, 1'b1, 1'b1);
		cyc(10, 0, 0, 4, 1'b1, 1'b0);
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("latched", {7'h00, latched}, 8'h00);
		chk("event_count", {5'h00, event_count}, 8'h00);
		@(posedge clock);
		arst_n <= 1'b1;
		cyc(10, 8, 1, 1, 1'b0, 1'b1);
		print_verdict;
	end
	// cut a hang short well past the expected run of about 500 cycles
	initial
	begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		print_verdict;
	end
endmodule

// *** rtl/pll_latch_off.sv ***
// pll_latch_off: latch-off protection on the power-limit/latch pin
// assumes comparator, gate request and switching clock pins are
// asynchronous; arst_n is the supply dropping below supply_reset_level
`timescale 1ns/1ps
module pll_latch_off
	import pll_pkg::*;
#(
	parameter int BLANK = BLANK_CYCLES,
	parameter int QUALIFY = QUALIFY_CYCLES,
	parameter int EVENTS = EVENTS_TO_LATCH
)
(
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// pins
	input wire logic trip_compare,
	input wire logic gate_request,
	input wire logic switch_clock,
	// outputs
	output logic gate_drive,
	output logic latched,
	output logic [pll_pkg::EVENT_W-1:0] event_count,
	output logic event_pulse
);
	import pll_pkg::*;

	logic trip_s;
	logic gate_s;
	logic swclk_s;
	logic gate_prev;
	logic swclk_prev;
	logic turn_off;
	logic cycle_start;
	pll_state_t state;
	pll_state_t next_state;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic [EVENT_W-1:0] next_event_count;
	logic next_latched;
	logic next_event_pulse;
	logic next_gate_drive;
	logic next_gate_prev;
	logic next_swclk_prev;
	logic qualified;

	// ==========================================
	// input synchronisers
	pll_sync u_sync_trip (.clock(clock), .arst_n(arst_n),
		.level_in(trip_compare), .level_out(trip_s));
	pll_sync u_sync_gate (.clock(clock), .arst_n(arst_n),
		.level_in(gate_request), .level_out(gate_s));
	pll_sync u_sync_swclk (.clock(clock), .arst_n(arst_n),
		.level_in(switch_clock), .level_out(swclk_s));

	assign turn_off = gate_prev && !gate_s;
	assign cycle_start = swclk_s && !swclk_prev;

	// ==========================================
	// checker, counter and latch
	always_comb
	begin
		next_state = state;
		next_timer = timer;
		next_event_count = event_count;
		next_latched = latched;
		next_event_pulse = 1'b0;
		next_gate_prev = gate_s;
		next_swclk_prev = swclk_s;
		qualified = 1'b0;
		unique case (state)
			PLL_IDLE:
			begin
				if (turn_off)
				begin
					next_state = PLL_BLANK;
					next_timer = TIMER_ZERO;
				end
			end
			PLL_BLANK:
			begin
				// comparator is not looked at while blanking
				if (gate_s)
					next_state = PLL_IDLE;
				else if (timer >= TIMER_W'(BLANK - 1))
				begin
					next_state = PLL_QUAL;
					next_timer = TIMER_ZERO;
				end
				else
					next_timer = timer + 1'b1;
			end
			PLL_QUAL:
			begin
				// only the off-time is checked, once per cycle
				if (gate_s || cycle_start)
					next_state = PLL_IDLE;
				else if (!trip_s)
					next_timer = TIMER_ZERO;
				else if (timer >= TIMER_W'(QUALIFY - 1))
				begin
					qualified = 1'b1;
					next_state = PLL_DONE;
				end
				else
					next_timer = timer + 1'b1;
			end
			PLL_DONE:
			begin
				if (cycle_start)
					next_state = PLL_IDLE;
			end
		endcase
		if (qualified)
		begin
			next_event_pulse = 1'b1;
			if (event_count >= EVENT_W'(EVENTS - 1))
				next_latched = 1'b1;
			next_event_count = event_count + EVENT_ONE;
		end
		// a switching cycle ended with no qualified event
		if (cycle_start && state != PLL_DONE && !qualified)
			next_event_count = EVENT_ZERO;
		// the latch only drops by reset from the supply monitor
		if (latched)
			next_latched = 1'b1;
		// gated combinationally too, so the very first latched cycle
		// already blocks the pulse
		next_gate_drive = gate_s && !next_latched;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= PLL_IDLE;
			timer <= TIMER_ZERO;
			event_count <= EVENT_ZERO;
			latched <= 1'b0;
			event_pulse <= 1'b0;
			gate_drive <= 1'b0;
			gate_prev <= 1'b0;
			swclk_prev <= 1'b0;
		end
		else
		begin
			state <= next_state;
			timer <= next_timer;
			event_count <= next_event_count;
			latched <= next_latched;
			event_pulse <= next_event_pulse;
			gate_drive <= next_gate_drive;
			gate_prev <= next_gate_prev;
			swclk_prev <= next_swclk_prev;
		end
	end

	// ==========================================
	// checks
	// the event that brings the successive count up to the latch level
	sequence s_fourth_event;
		event_pulse && event_count == EVENT_W'(EVENTS);
	endsequence

	// latch set and the gate already held off in the same cycle
	sequence s_latched_off;
		latched && !gate_drive;
	endsequence

	property p_gate_off;
		@(posedge clock) disable iff (!arst_n)
		latched |-> !gate_drive;
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("gate drive while latched");

	property p_latch_holds;
		@(posedge clock) disable iff (!arst_n)
		latched |=> latched;
	endproperty
	a_latch_holds: assert property (p_latch_holds)
		else $error("latch cleared without reset");

	property p_blank;
		@(posedge clock) disable iff (!arst_n)
		(state == PLL_IDLE && turn_off) |=>
			(state == PLL_BLANK || state == PLL_IDLE);
	endproperty
	a_blank: assert property (p_blank)
		else $error("check started without blanking");

	property p_qual_len;
		@(posedge clock) disable iff (!arst_n)
		$rose(event_pulse) |-> $past(trip_s, 2);
	endproperty
	a_qual_len: assert property (p_qual_len)
		else $error("event without comparator high");

	property p_latch_cause;
		@(posedge clock) disable iff (!arst_n)
		$rose(latched) |-> s_fourth_event;
	endproperty
	a_latch_cause: assert property (p_latch_cause)
		else $error("latched without enough events");

	property p_one_per_cycle;
		@(posedge clock) disable iff (!arst_n)
		event_pulse |=> !event_pulse;
	endproperty
	a_one_per_cycle: assert property (p_one_per_cycle)
		else $error("two events back to back");

	property p_clear;
		@(posedge clock) disable iff (!arst_n)
		(cycle_start && state == PLL_IDLE) |=> event_count == EVENT_ZERO;
	endproperty
	a_clear: assert property (p_clear)
		else $error("count kept after empty cycle");

	property p_latch_after_four;
		@(posedge clock) disable iff (!arst_n)
		s_fourth_event |-> s_latched_off;
	endproperty
	a_latch_after_four: assert property (p_latch_after_four)
		else $error("four events did not latch");
endmodule

// *** rtl/pll_pkg.sv ***
// pll_pkg: constants for the protection latch-off logic
// assumes a 200 MHz core clock; timings given in ns
package pll_pkg;
	// ==========================================
	// timing
	localparam int CLOCK_PERIOD_NS = 5;
	localparam int BLANK_TIME_NS = 250;
	localparam int QUALIFY_TIME_NS = 1000;
	// blanking is a least time: round up
	localparam int BLANK_CYCLES =
		(BLANK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	// qualifying high is a least time: round up
	localparam int QUALIFY_CYCLES =
		(QUALIFY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	// ==========================================
	// counting
	localparam int EVENTS_TO_LATCH = 4;
	localparam int TIMER_W = 16;
	localparam int EVENT_W = 3;
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
	localparam logic [EVENT_W-1:0] EVENT_ZERO = 3'h0;
	localparam logic [EVENT_W-1:0] EVENT_ONE = 3'h1;
	// per-cycle checker states
	typedef enum logic [3:0]
	{
		PLL_IDLE = 4'b0001,
		PLL_BLANK = 4'b0010,
		PLL_QUAL = 4'b0100,
		PLL_DONE = 4'b1000
	} pll_state_t;
endpackage

// *** rtl/pll_sync.sv ***
// pll_sync: two-flop synchroniser for an asynchronous level
// assumes the level may change at any time relative to clock
`timescale 1ns/1ps
module pll_sync
(
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// level
	input wire logic level_in,
	output logic level_out
);
	logic stage1;
	logic next_stage1;
	logic next_level_out;

	always_comb
	begin
		next_stage1 = level_in;
		next_level_out = stage1;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1 <= 1'b0;
			level_out <= 1'b0;
		end
		else
		begin
			stage1 <= next_stage1;
			level_out <= next_level_out;
		end
	end
endmodule
